// ==== rtl/sri_pkg.sv ====
package sri_pkg;

	// Operand-size field.
	localparam logic SIZE_BYTE = 1'b0;
	localparam logic SIZE_WORD = 1'b1;

	// Indirect-addressing prefix byte.
	localparam logic [7:0] INDIRECT_PREFIX = 8'h09;

	// Five-bit operand codes.
	localparam logic [4:0] MODE_REG_LO0  = 5'h12;
	localparam logic [4:0] MODE_REG_LO1  = 5'h13;
	localparam logic [4:0] MODE_REG_HI0  = 5'h10;
	localparam logic [4:0] MODE_REG_HI1  = 5'h11;
	localparam logic [4:0] MODE_AREG0    = 5'h02;
	localparam logic [4:0] MODE_AREG1    = 5'h03;
	localparam logic [3:0] MODE_IND_PFX  = 4'h0;
	localparam logic [3:0] MODE_D8A_PFX  = 4'h2;
	localparam logic [4:0] MODE_D8_SB    = 5'h06;
	localparam logic [4:0] MODE_D8_FB    = 5'h07;
	localparam logic [2:0] MODE_D16_PFX  = 3'h2;
	localparam logic [3:0] MODE_D24A_PFX = 4'h6;
	localparam logic [4:0] MODE_ABS16    = 5'h0F;
	localparam logic [4:0] MODE_ABS24    = 5'h0E;

	// Extension bytes carried by each displacement width.
	localparam logic [3:0] EXT_NONE = 4'h0;
	localparam logic [3:0] EXT_8    = 4'h1;
	localparam logic [3:0] EXT_16   = 4'h2;
	localparam logic [3:0] EXT_24   = 4'h3;

	// Control-register selector codes.
	localparam logic [2:0] SEL_GRP2_ISP = 3'h7;
	localparam logic [2:0] SEL_GRP2_FB  = 3'h3;

	// Register-pair index for the long register forms.
	localparam logic [1:0] PAIR_TWO_ZERO   = 2'h0;
	localparam logic [1:0] PAIR_THREE_ONE  = 2'h1;

	// Byte and cycle costs.
	localparam logic [3:0] BYTES_ONE      = 4'h1;
	localparam logic [3:0] BYTES_TWO      = 4'h2;
	localparam logic [3:0] BYTES_SIX      = 4'h6;
	localparam logic [9:0] CYC_ONE        = 10'h001;
	localparam logic [9:0] CYC_TWO        = 10'h002;
	localparam logic [9:0] CYC_THREE      = 10'h003;
	localparam logic [9:0] CYC_FOUR       = 10'h004;
	localparam logic [9:0] CYC_FIVE       = 10'h005;
	localparam logic [9:0] CYC_SIX        = 10'h006;
	localparam logic [9:0] CYC_SEVEN      = 10'h007;
	localparam logic [3:0] IND_EXTRA_BYTE = 4'h1;
	localparam logic [9:0] IND_EXTRA_CYC  = 10'h003;

	typedef enum logic [3:0] {
		OP_POP,
		OP_CTRL_POP1,
		OP_CTRL_POP2,
		OP_RESTORE,
		OP_PUSH_IMM,
		OP_PUSH,
		OP_PUSH_LIMM,
		OP_PUSH_L,
		OP_PUSH_EA,
		OP_CTRL_PUSH1,
		OP_CTRL_PUSH2,
		OP_SAVE,
		OP_INT_RETURN,
		OP_MAC_REPEAT,
		OP_ROT_LEFT_C,
		OP_ROT_RIGHT_C
	} sri_op_t;

	typedef enum logic [1:0] {
		MK_REG,
		MK_AREG,
		MK_IND,
		MK_MEM
	} sri_mode_t;

	typedef struct packed {
		logic [7:0] lead_byte;
		sri_op_t    op;
		logic       rot_count;
		logic       size;
		logic [4:0] mode;
		logic [2:0] sel;
		logic [7:0] mask;
		logic [3:0] count;
		logic [7:0] reps;
	} sri_req_t;

	typedef struct packed {
		logic       undefined;
		logic       indirect;
		logic       word;
		sri_mode_t  kind;
		logic [1:0] reg_idx;
		logic       reg_high;
		logic       ctrl_group2;
		logic [2:0] ctrl_sel;
		logic [7:0] reg_list;
		logic       rot_right;
		logic [3:0] rot_amount;
		logic [3:0] bytes;
		logic [9:0] cycles;
	} sri_res_t;

endpackage : sri_pkg

// ==== rtl/sri_operand_decode.sv ====
`timescale 1ns/1ps
module sri_operand_decode (
	// Operand field
	input  wire logic [4:0]        mode,
	input  wire logic              long_form,
	// Decoded operand
	output sri_pkg::sri_mode_t     kind,
	output logic [3:0]             ext_bytes,
	output logic [1:0]             reg_idx,
	output logic                   reg_high,
	output logic                   bad
);
	import sri_pkg::*;

	wire is_reg_lo = (mode == MODE_REG_LO0) || (mode == MODE_REG_LO1);
	wire is_reg_hi = (mode == MODE_REG_HI0) || (mode == MODE_REG_HI1);
	wire is_areg   = (mode == MODE_AREG0) || (mode == MODE_AREG1);
	wire is_ind    = (mode[4:1] == MODE_IND_PFX);
	wire is_d8     = (mode[4:1] == MODE_D8A_PFX) || (mode == MODE_D8_SB) || (mode == MODE_D8_FB);
	wire is_d16    = (mode[4:2] == MODE_D16_PFX) || (mode == MODE_ABS16);
	wire is_d24    = (mode[4:1] == MODE_D24A_PFX) || (mode == MODE_ABS24);

	// Codes above the register-direct group are not assigned to any mode.
	wire known = is_reg_lo | is_reg_hi | is_areg | is_ind | is_d8 | is_d16 | is_d24;

	assign kind = (is_reg_lo | is_reg_hi) ? MK_REG :
		is_areg ? MK_AREG :
		is_ind ? MK_IND : MK_MEM;
	assign ext_bytes = is_d8 ? EXT_8 : is_d16 ? EXT_16 : is_d24 ? EXT_24 : EXT_NONE;
	assign reg_idx = {1'b0, mode[0]};
	assign reg_high = is_reg_hi;
	// The long forms have no high-half register codes.
	assign bad = !known || (long_form && is_reg_hi);

endmodule : sri_operand_decode

// ==== rtl/sri_decode.sv ====
`timescale 1ns/1ps
// Summary of operation
// - size bit 0 is byte, 1 is word.
// - register-direct codes select data and address registers.
// - memory codes select indirect, displacement and absolute.
// - prefix byte 00001001 marks indirect operand.
// - indirect adds one byte and three cycles.
// - sized pop is three cycles, two to five bytes.
// - first control group selectors; pop two bytes, three cycles.
// - second control group selectors; two bytes, four cycles.
// - first control group push two bytes, one cycle.
// - restore two bytes, one plus weighted count cycles.
// - save two bytes, weighted count cycles.
// - immediate push one cycle, two bytes, word adds one.
// - sized push one cycle register, three memory.
// - long push two or five cycles; immediate six/three.
// - long register codes select pairs; high codes undefined.
// - effective-address push only displacement or absolute modes.
// - repeated multiply-accumulate two bytes, seven plus 2m.
// - count rotate two cycles register, four memory.
// - carry rotates one cycle register, three memory.
module sri_decode (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              srst,
	// Request
	input  wire logic              req_valid,
	input  wire sri_pkg::sri_req_t req,
	// Result
	output logic                   res_valid,
	output sri_pkg::sri_res_t      res
);
	import sri_pkg::*;

	// Weighted register count: data registers once, address and base twice.
	function automatic logic [4:0] weighted_count(input logic [7:0] list);
		logic [4:0] acc;
		acc = 5'h00;
		for (int i = 0; i < 8; i++)
		begin
			if (list[i])
				acc = acc + ((i < 4) ? 5'h01 : 5'h02);
		end
		return acc;
	endfunction : weighted_count

	sri_mode_t   mode_kind;
	logic [3:0]  ext_bytes;
	logic [1:0]  reg_idx;
	logic        reg_high;
	logic        mode_bad;
	logic        long_form;
	logic        res_valid_q;
	sri_res_t    res_q;
	sri_res_t    res_d;
	logic [3:0]  base_bytes;
	logic [9:0]  base_cycles;
	logic        op_bad;
	logic        uses_mode;
	logic        may_indirect;

	assign long_form = (req.op == OP_PUSH_L);

	sri_operand_decode u_operand (
		.mode      (req.mode),
		.long_form (long_form),
		.kind      (mode_kind),
		.ext_bytes (ext_bytes),
		.reg_idx   (reg_idx),
		.reg_high  (reg_high),
		.bad       (mode_bad)
	);

	wire        is_memory   = (mode_kind == MK_IND) || (mode_kind == MK_MEM);
	wire        prefix_seen = (req.lead_byte == INDIRECT_PREFIX);
	wire        size_word   = (req.size == SIZE_WORD);
	// Save masks are bit-reversed so both forms share one register list.
	wire [7:0]  save_list   = {req.mask[0], req.mask[1], req.mask[2], req.mask[3],
		req.mask[4], req.mask[5], req.mask[6], req.mask[7]};
	wire [7:0]  reg_list    = (req.op == OP_SAVE) ? save_list : req.mask;
	wire [4:0]  weight      = weighted_count(reg_list);
	wire [9:0]  mac_cycles  = CYC_SEVEN + {1'b0, req.reps, 1'b0};
	wire        grp2_unused = (req.sel > SEL_GRP2_FB) && (req.sel != SEL_GRP2_ISP);
	wire [3:0]  ind_bytes   = prefix_seen ? IND_EXTRA_BYTE : 4'h0;
	wire [9:0]  ind_cycles  = prefix_seen ? IND_EXTRA_CYC : 10'h000;
	wire [9:0]  reg_or_mem3 = is_memory ? CYC_THREE : CYC_ONE;

	always_comb
	begin
		base_bytes   = BYTES_TWO + ext_bytes;
		base_cycles  = CYC_ONE;
		op_bad       = 1'b0;
		uses_mode    = 1'b1;
		may_indirect = 1'b0;
		case (req.op)
			OP_POP:
			begin
				base_cycles  = CYC_THREE;
				may_indirect = 1'b1;
			end
			OP_CTRL_POP1, OP_CTRL_PUSH1:
			begin
				base_bytes  = BYTES_TWO;
				base_cycles = (req.op == OP_CTRL_POP1) ? CYC_THREE : CYC_ONE;
				uses_mode   = 1'b0;
			end
			OP_CTRL_POP2, OP_CTRL_PUSH2:
			begin
				base_bytes  = BYTES_TWO;
				base_cycles = CYC_FOUR;
				op_bad      = grp2_unused;
				uses_mode   = 1'b0;
			end
			OP_RESTORE, OP_SAVE:
			begin
				base_bytes  = BYTES_TWO;
				base_cycles = (req.op == OP_RESTORE) ? CYC_ONE + {5'h00, weight}
					: {5'h00, weight};
				uses_mode   = 1'b0;
			end
			OP_PUSH_IMM:
			begin
				base_bytes  = size_word ? BYTES_TWO + BYTES_ONE : BYTES_TWO;
				base_cycles = CYC_ONE;
				uses_mode   = 1'b0;
			end
			OP_PUSH:
			begin
				base_cycles  = reg_or_mem3;
				may_indirect = 1'b1;
			end
			OP_PUSH_LIMM:
			begin
				base_bytes  = BYTES_SIX;
				base_cycles = CYC_THREE;
				uses_mode   = 1'b0;
			end
			OP_PUSH_L:
			begin
				base_cycles  = is_memory ? CYC_FIVE : CYC_TWO;
				may_indirect = 1'b1;
			end
			OP_PUSH_EA:
			begin
				base_cycles = CYC_THREE;
				op_bad      = (mode_kind != MK_MEM);
			end
			OP_INT_RETURN:
			begin
				base_bytes  = BYTES_ONE;
				base_cycles = CYC_SIX;
				uses_mode   = 1'b0;
			end
			OP_MAC_REPEAT:
			begin
				base_bytes  = BYTES_TWO;
				base_cycles = mac_cycles;
				uses_mode   = 1'b0;
			end
			OP_ROT_LEFT_C, OP_ROT_RIGHT_C:
			begin
				if (req.rot_count)
					base_cycles = is_memory ? CYC_FOUR : CYC_TWO;
				else
					base_cycles = reg_or_mem3;
				may_indirect = 1'b1;
			end
			default:
			begin
				op_bad = 1'b1;
			end
		endcase
	end

	always_comb
	begin
		res_d             = '0;
		res_d.indirect    = prefix_seen && may_indirect;
		// A prefix on a form that cannot take it, or an unused code, is undefined.
		res_d.undefined   = op_bad || (uses_mode && mode_bad)
			|| (prefix_seen && !may_indirect);
		res_d.word        = size_word;
		res_d.kind        = mode_kind;
		res_d.reg_idx     = long_form ? (req.mode[0] ? PAIR_THREE_ONE : PAIR_TWO_ZERO) : reg_idx;
		res_d.reg_high    = reg_high;
		res_d.ctrl_group2 = (req.op == OP_CTRL_POP2) || (req.op == OP_CTRL_PUSH2);
		res_d.ctrl_sel    = req.sel;
		res_d.reg_list    = reg_list;
		res_d.rot_right   = req.count[3];
		res_d.rot_amount  = {1'b0, req.count[2:0]} + 4'h1;
		res_d.bytes       = base_bytes + ind_bytes;
		res_d.cycles      = base_cycles + ind_cycles;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			res_valid_q <= 1'b0;
			res_q       <= '0;
		end
		else
		begin
			res_valid_q <= req_valid;
			if (req_valid)
				res_q <= res_d;
		end
	end

	assign res_valid = res_valid_q;
	assign res       = res_q;

endmodule : sri_decode

// ==== sim/sri_decode_chk.sv ====
`timescale 1ns/1ps
module sri_decode_chk
	import sri_pkg::*;
(
	input wire logic     clock,
	input wire logic     srst,
	input wire logic     req_valid,
	input wire sri_req_t req,
	input wire logic     res_valid,
	input wire sri_res_t res
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	sequence s_take(sri_op_t o);
		req_valid && req.op == o;
	endsequence

	chk_answer_next: assert property (req_valid |=> res_valid)
		else $error("no answer one cycle after a request");
	chk_idle_quiet: assert property (!req_valid |=> !res_valid && $stable(res))
		else $error("result moved without a request");
	chk_size_word: assert property (s_take(OP_POP) |=> res.word == $past(req.size))
		else $error("size bit not reflected");
	chk_ctrl_pop_cost: assert property (s_take(OP_CTRL_POP1) ##0 req.lead_byte != INDIRECT_PREFIX
		|=> res.bytes == BYTES_TWO && res.cycles == CYC_THREE)
		else $error("control pop cost wrong");
	chk_group2_unused: assert property (s_take(OP_CTRL_POP2) ##0 req.sel inside {[4:6]} |=> res.undefined)
		else $error("unused selector accepted");
	chk_save_weight: assert property (s_take(OP_SAVE) ##0 req.lead_byte != INDIRECT_PREFIX
		|=> res.cycles == $countones($past(req.mask[7:4])) + 2 * $countones($past(req.mask[3:0])))
		else $error("save cycle count wrong");
	chk_restore_weight: assert property (s_take(OP_RESTORE) ##0 req.lead_byte != INDIRECT_PREFIX
		|=> res.cycles == 1 + 2 * $countones($past(req.mask[7:4])) + $countones($past(req.mask[3:0])))
		else $error("restore cycle count wrong");
	chk_mac_cost: assert property (s_take(OP_MAC_REPEAT) |=> res.cycles == 7 + 2 * $past(req.reps))
		else $error("repeat multiply cycle count wrong");
	chk_count_field: assert property (s_take(OP_ROT_LEFT_C) ##0 req.rot_count
		|=> res.rot_right == $past(req.count[3]) && res.rot_amount == $past(req.count[2:0]) + 1)
		else $error("rotate count decoded wrong");
	chk_prefix_flag: assert property (req_valid |=> res.indirect == ($past(req.lead_byte) == INDIRECT_PREFIX
		&& $past(req.op) inside {OP_POP, OP_PUSH, OP_PUSH_L, OP_ROT_LEFT_C, OP_ROT_RIGHT_C}))
		else $error("indirect flag wrong");
	chk_restore_list: assert property (s_take(OP_RESTORE) |=> res.reg_list == $past(req.mask))
		else $error("restore list wrong");
	chk_save_list: assert property (s_take(OP_SAVE) |=> res.reg_list[0] == $past(req.mask[7])
		&& res.reg_list[7] == $past(req.mask[0]) && res.reg_list[4] == $past(req.mask[3]))
		else $error("save list not reversed");
	chk_ctrl_select: assert property (s_take(OP_CTRL_PUSH2) |=> res.ctrl_group2 && res.ctrl_sel == $past(req.sel))
		else $error("control selector wrong");
	chk_long_pair: assert property (s_take(OP_PUSH_L) ##0 req.mode == MODE_REG_LO1
		|=> res.reg_idx == PAIR_THREE_ONE && res.kind == MK_REG)
		else $error("long register pair wrong");
	chk_high_reg: assert property (s_take(OP_POP) ##0 req.mode == MODE_REG_HI0
		|=> res.reg_high && res.kind == MK_REG && res.reg_idx == 2'h0)
		else $error("high register code wrong");
endmodule : sri_decode_chk

bind sri_decode sri_decode_chk chk_u (.clock(clock), .srst(srst), .req_valid(req_valid), .req(req),
	.res_valid(res_valid), .res(res));

// ==== sim/test_stack_rotate_instruction_decode.sv ====
`timescale 1ns/1ps
`define CMP(n, a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("unexpected %s exp %h got %h", n, b, a); end end
module test_stack_rotate_instruction_decode;
	import sri_pkg::*;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic        req_valid = 1'b0;
	sri_req_t    req = '0;
	logic        res_valid;
	sri_res_t    res;
	int          n_errors = 0;
	int          num_checks = 0;
	logic [31:0] seed = 32'h5A581935;
	logic [31:0] r;
	logic [14:0] exp_q[$];
	logic [14:0] e;
	logic        u;
	logic        ind;
	logic [4:0]  m;
	sri_op_t     tops [7] = '{OP_POP, OP_PUSH, OP_PUSH_L, OP_PUSH_EA, OP_ROT_LEFT_C, OP_ROT_LEFT_C, OP_ROT_RIGHT_C};
	int          creg [7] = '{3, 1, 2, 3, 2, 1, 1};
	int          cmem [7] = '{3, 3, 5, 3, 4, 3, 3};

	sri_decode dut_u (.clock(clock), .srst(srst), .req_valid(req_valid), .req(req), .res_valid(res_valid), .res(res));

	always #12.5 clock = ~clock;

	function automatic logic [31:0] nx();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : nx

	function automatic int ext(logic [4:0] a);
		if (a[4] || a[4:2] == 3'h0)
			return 0;
		if (a[4:2] != 3'h3)
			return a[4:2];
		return a == 5'h0F ? 2 : 3;
	endfunction : ext

	// Random fields come from r; only undefined is compared when a refusal is expected.
	task automatic go(sri_op_t op, logic [4:0] md, logic pi, logic rc, logic uu, int b, int c);
		@(posedge clock);
		req_valid <= 1'b1;
		req <= '{lead_byte: pi ? INDIRECT_PREFIX : 8'h00, op: op, rot_count: rc, size: r[11], mode: md,
			sel: r[10:8], mask: r[7:0], count: r[15:12], reps: r[23:16]};
		exp_q.push_back({uu, 4'(b), 10'(c)});
	endtask : go

	task automatic done(string s);
		@(posedge clock);
		req_valid <= 1'b0;
		repeat (3) @(posedge clock);
		$display("test %s finished", s);
	endtask : done

	task automatic complete_run;
		// An answer still owed at the end means a result never appeared.
		if (exp_q.size() != 0)
			n_errors++;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	always @(negedge clock)
		if (res_valid === 1'b1)
		begin
			e = exp_q.pop_front();
			if (e[14])
				`CMP("undefined", res.undefined, 1'b1)
			else
				`CMP("cost", {res.undefined, res.bytes, res.cycles}, e)
		end

	initial
	begin
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		for (int i = 0; i < 7; i++)
			for (int k = 0; k < 32; k++)
			begin
				r = nx();
				m = 5'(k);
				ind = r[24];
				u = m[4] && m[3:2] != 2'h0 || i == 2 && m[4:1] == 4'h8 || i == 3 && (m[4] || m[4:2] == 3'h0 || ind);
				go(tops[i], m, ind, i == 4, u, 2 + ext(m) + ind,
					(m[4] || m[4:1] == 4'h1 ? creg[i] : cmem[i]) + 3 * ind);
			end
		done("operand modes");
		for (int s = 0; s < 8; s++)
		begin
			r = nx();
			r[10:8] = 3'(s);
			go(OP_CTRL_POP1, 5'h00, 1'b0, 1'b0, 1'b0, 2, 3);
			go(OP_CTRL_PUSH1, 5'h00, 1'b0, 1'b0, 1'b0, 2, 1);
			go(OP_CTRL_POP2, 5'h00, 1'b0, 1'b0, s inside {[4:6]}, 2, 4);
			go(OP_CTRL_PUSH2, 5'h00, 1'b0, 1'b0, s inside {[4:6]}, 2, 4);
		end
		go(OP_CTRL_POP1, 5'h00, 1'b1, 1'b0, 1'b1, 0, 0);
		done("control registers");
		for (int k = 0; k < 24; k++)
		begin
			r = nx();
			if (k < 2)
				r[7:0] = k ? 8'hFF : 8'h00;
			go(OP_SAVE, 5'h00, 1'b0, 1'b0, 1'b0, 2, $countones(r[7:4]) + 2 * $countones(r[3:0]));
			go(OP_RESTORE, 5'h00, 1'b0, 1'b0, 1'b0, 2, 1 + 2 * $countones(r[7:4]) + $countones(r[3:0]));
			go(OP_MAC_REPEAT, 5'h00, 1'b0, 1'b0, 1'b0, 2, 7 + 2 * r[23:16]);
			go(OP_PUSH_IMM, 5'h00, 1'b0, 1'b0, 1'b0, 2 + r[11], 1);
			go(OP_PUSH_LIMM, 5'h00, 1'b0, 1'b0, 1'b0, 6, 3);
			go(OP_INT_RETURN, 5'h00, 1'b0, 1'b0, 1'b0, 1, 6);
		end
		done("masks and fixed costs");
		complete_run();
	end

	initial
	begin
		#(25 * 3000);
		n_errors++;
		complete_run();
	end
endmodule : test_stack_rotate_instruction_decode
